// >>> rtl/brc_pkg.sv
// Package of constants and types for the regulator control register bank
// Notes on behaviour
// - First byte: address with msb one, R/W
// - Second byte selects register, upper five zero
// - Primary code: 0x00 is 400mV, 5mV steps
// - Alternate code same encoding, both reset 0x64
// - Control at 0x03 reset 0x6F; status 0x05
// - Control bit7 written one resets everything
// - Bit6 forces pulse width mode during changes
// - Bit5 clear disables, set restarts without delay
// - Bit4 selects power-save or forced pulse width
// - Bit3 enables active output discharge
// - Bit2 selects retry or latch-off short protection
// - Bits1:0 set time per voltage step
// - Status bit4 latches thermal warning
// - Status bit3 latches retry protection entry
// - Status bit0 latches input undervoltage
// - Status flags held until reset or read
// - Write lands at falling edge after ack
// - Unimplemented addresses read back 00h
// - Soft reset restarts; writes blocked during delay
// - Chip activate falling edge resets registers
package brc_pkg;
  localparam logic [7:0] REG_PRIMARY = 8'h01;
  localparam logic [7:0] REG_ALTERNATE = 8'h02;
  localparam logic [7:0] REG_CONTROL = 8'h03;
  localparam logic [7:0] REG_FLAGS = 8'h05;
  localparam logic [7:0] RST_VOLTAGE = 8'h64;
  localparam logic [7:0] RST_CONTROL = 8'h6F;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  localparam int CTL_SOFT_RESET = 7;
  localparam int CTL_FORCED_PULSE_WIDTH_MODE_ON_CHANGE = 6;
  localparam int CTL_ENABLE = 5;
  localparam int CTL_FORCED_PULSE_WIDTH_MODE = 4;
  localparam int CTL_DISCHARGE = 3;
  localparam int CTL_RETRY = 2;
  localparam int FLG_THERMAL = 4;
  localparam int FLG_RETRY = 3;
  localparam int FLG_UNDERVOLT = 0;
  localparam logic [7:0] FLG_USED_MASK = 8'h19;
  localparam logic [6:0] ADDR_MSB_MASK = 7'h40;
  localparam logic [4:0] SEL_UPPER_ZERO = 5'h00;
  localparam int CLK_MHZ = 250;
  // Start delay after soft reset, in microseconds
  localparam int START_DELAY_US = 500;
  localparam int START_DELAY_CYC = START_DELAY_US * CLK_MHZ;
  // Step times in nanoseconds
  localparam int STEP0_NS = 250;
  localparam int STEP1_NS = 500;
  localparam int STEP2_NS = 1000;
  localparam int STEP3_NS = 5000;
  localparam int CLK_NS = 4;
  localparam int STEP0_CYC = STEP0_NS / CLK_NS;
  localparam int STEP1_CYC = STEP1_NS / CLK_NS;
  localparam int STEP2_CYC = STEP2_NS / CLK_NS;
  localparam int STEP3_CYC = STEP3_NS / CLK_NS;
  localparam int STEP_W = 11;

  // Serial engine states, Gray along the usual path
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR_ACK = 3'b011,
    ST_RX = 3'b010,
    ST_RX_ACK = 3'b110,
    ST_TX = 3'b111,
    ST_TX_ACK = 3'b101
  } brc_state_type;

  // Serial engine state record
  typedef struct packed {
    brc_state_type st;
    logic [3:0] bits;
    logic [7:0] shreg;
    logic rnw;
    logic have_sel;
    logic [7:0] sel;
    logic sda_oe;
    logic wr_pulse;
    logic [7:0] wr_data;
    logic rd_pulse;
  } brc_ser_type;
endpackage

// >>> rtl/brc_serial.sv
// Two-wire serial target engine of the register bank
`timescale 1ns/1ps
module brc_serial (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_s,
  input wire logic sda_s,
  input wire logic [6:0] own_addr,
  input wire logic [7:0] rd_data,
  output logic sda_oe,
  output logic wr_pulse,
  output logic [7:0] wr_sel,
  output logic [7:0] wr_data,
  output logic rd_pulse
);
  brc_pkg::brc_ser_type q, d;
  logic scl_d, sda_d; // Previous synchronised levels
  logic scl_rise, scl_fall, start_c, stop_c;

  // Edge history of synchronised bus lines
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_c = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_c = scl_s & scl_d & ~sda_d & sda_s;

  // Next state of the engine
  always_comb begin
    d = q;
    d.wr_pulse = 1'b0;
    d.rd_pulse = 1'b0;
    if (start_c) begin
      // Start or repeated start: address byte follows
      d.st = brc_pkg::ST_ADDR;
      d.bits = 4'h0;
      d.sda_oe = 1'b0;
    end else if (stop_c) begin
      d.st = brc_pkg::ST_IDLE;
      d.sda_oe = 1'b0;
      d.have_sel = 1'b0;
    end else begin
      case (q.st)
        brc_pkg::ST_ADDR, brc_pkg::ST_RX: begin
          // Sample on rising clock, msb first
          if (scl_rise) begin
            d.shreg = {q.shreg[6:0], sda_s};
            d.bits = q.bits + 4'h1;
          end else if (scl_fall && q.bits == 4'h8) begin
            d.bits = 4'h0;
            if (q.st == brc_pkg::ST_ADDR) begin
              // Match own address; msb must be one
              if (q.shreg[7:1] == own_addr && (q.shreg[7:1] & brc_pkg::ADDR_MSB_MASK) != 7'h00) begin
                d.rnw = q.shreg[0];
                d.st = brc_pkg::ST_ADDR_ACK;
                d.sda_oe = 1'b1;
              end else begin
                d.st = brc_pkg::ST_IDLE;
              end
            end else begin
              // First data byte is the register select
              d.st = brc_pkg::ST_RX_ACK;
              d.sda_oe = 1'b1;
              // Select is captured here, counted only once its ack ends
              if (!q.have_sel) begin
                d.sel = q.shreg;
              end
            end
          end
        end
        brc_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (q.rnw) begin
              // Read: drive first bit of selected register
              d.st = brc_pkg::ST_TX;
              d.shreg = rd_data;
              d.sda_oe = ~rd_data[7];
              d.bits = 4'h1;
            end else begin
              d.st = brc_pkg::ST_RX;
              d.sda_oe = 1'b0;
              d.have_sel = 1'b0;
            end
          end
        end
        brc_pkg::ST_RX_ACK: begin
          if (scl_fall) begin
            d.st = brc_pkg::ST_RX;
            d.sda_oe = 1'b0;
            if (q.have_sel) begin
              // Data byte lands on ack falling edge; a wide select drops it
              if (q.sel[7:3] == brc_pkg::SEL_UPPER_ZERO) begin
                d.wr_pulse = 1'b1;
              end
            end else begin
              // Select byte acked, later bytes are data whatever their value
              d.have_sel = 1'b1;
            end
            d.wr_data = q.shreg;
          end
        end
        brc_pkg::ST_TX: begin
          if (scl_fall) begin
            if (q.bits == 4'h8) begin
              d.st = brc_pkg::ST_TX_ACK;
              d.sda_oe = 1'b0;
              d.rd_pulse = 1'b1;
            end else begin
              d.sda_oe = ~q.shreg[3'(7 - q.bits)];
              d.bits = q.bits + 4'h1;
            end
          end
        end
        brc_pkg::ST_TX_ACK: begin
          // Host ack keeps going, nack ends read
          if (scl_rise) begin
            d.st = sda_s ? brc_pkg::ST_IDLE : brc_pkg::ST_TX_ACK;
            d.rnw = ~sda_s;
          end else if (scl_fall && q.rnw) begin
            d.st = brc_pkg::ST_TX;
            d.shreg = rd_data;
            d.sda_oe = ~rd_data[7];
            d.bits = 4'h1;
          end
        end
        default: d.st = brc_pkg::ST_IDLE;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sda_oe = q.sda_oe;
  assign wr_pulse = q.wr_pulse;
  assign wr_sel = q.sel;
  assign wr_data = q.wr_data;
  assign rd_pulse = q.rd_pulse;
endmodule

// >>> rtl/brc_top.sv
// Register bank of the step-down regulator behind a two-wire serial target
`timescale 1ns/1ps
module brc_top #(
  parameter int START_DELAY = brc_pkg::START_DELAY_CYC
) (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic [6:0] TARGET_ADDR,
  input wire logic CHIP_ACTIVATE,
  input wire logic THERMAL_WARN,
  input wire logic RETRY_ENTERED,
  input wire logic INPUT_UNDERVOLT,
  input wire logic VOLTAGE_CHANGING,
  output logic [7:0] PRIMARY_VOLTAGE_CODE,
  output logic [7:0] ALTERNATE_VOLTAGE_CODE,
  output logic CONVERTER_ENABLE,
  output logic RESTART_NO_DELAY,
  output logic FORCED_PULSE_WIDTH_MODE,
  output logic OUTPUT_DISCHARGE,
  output logic RETRY_SHORT_PROTECTION,
  output logic STEP_TICK,
  output logic START_PENDING
);
  typedef struct packed {
    logic [7:0] prim;
    logic [7:0] alt;
    logic [7:0] ctl;
    logic [7:0] flg;
    logic [31:0] delay;
    logic [10:0] step;
    logic tick;
    logic restart;
    logic forced_pulse_width_mode;
    logic sda_oe;
    logic act_d;
    logic pend; // Start delay still running
  } brc_top_type;

  brc_top_type q, d;
  logic [1:0] scl_m, sda_m, act_m, thr_m, ret_m, uv_m; // Two-stage synchronisers
  logic [6:0] adr_m0, adr_m1; // Strap address synchroniser stages
  logic [7:0] rd_data;
  logic [10:0] step_len;
  logic ser_oe, wr_pulse, rd_pulse;
  logic [7:0] wr_sel, wr_data;

  // Synchronise every pin except CLK_SYS, SYS_RST and VOLTAGE_CHANGING, first stage read only by second
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      scl_m <= 2'h3;
      sda_m <= 2'h3;
      act_m <= 2'h0;
      thr_m <= 2'h0;
      ret_m <= 2'h0;
      uv_m <= 2'h0;
      adr_m0 <= 7'h00;
      adr_m1 <= 7'h00;
    end else begin
      scl_m <= {scl_m[0], SCL_IN};
      sda_m <= {sda_m[0], SDA_IN};
      act_m <= {act_m[0], CHIP_ACTIVATE};
      thr_m <= {thr_m[0], THERMAL_WARN};
      ret_m <= {ret_m[0], RETRY_ENTERED};
      uv_m <= {uv_m[0], INPUT_UNDERVOLT};
      // Strap may move, so it is treated like any pin
      adr_m0 <= TARGET_ADDR;
      adr_m1 <= adr_m0;
    end
  end

  brc_serial u_serial (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .scl_s(scl_m[1]),
    .sda_s(sda_m[1]),
    .own_addr(adr_m1),
    .rd_data(rd_data),
    .sda_oe(ser_oe),
    .wr_pulse(wr_pulse),
    .wr_sel(wr_sel),
    .wr_data(wr_data),
    .rd_pulse(rd_pulse)
  );

  // Read mux; unmapped select reads zero
  always_comb begin
    if (wr_sel == brc_pkg::REG_PRIMARY) begin
      rd_data = q.prim;
    end else if (wr_sel == brc_pkg::REG_ALTERNATE) begin
      rd_data = q.alt;
    end else if (wr_sel == brc_pkg::REG_CONTROL) begin
      rd_data = q.ctl;
    end else if (wr_sel == brc_pkg::REG_FLAGS) begin
      rd_data = q.flg & brc_pkg::FLG_USED_MASK;
    end else begin
      rd_data = brc_pkg::READ_UNMAPPED;
    end
  end

  // Step time select from ramp speed field
  always_comb begin
    case (q.ctl[1:0])
      2'h0: step_len = 11'(brc_pkg::STEP0_CYC);
      2'h1: step_len = 11'(brc_pkg::STEP1_CYC);
      2'h2: step_len = 11'(brc_pkg::STEP2_CYC);
      default: step_len = 11'(brc_pkg::STEP3_CYC);
    endcase
  end

  // Register bank next state
  always_comb begin
    d = q;
    d.act_d = act_m[1];
    d.restart = 1'b0;
    d.sda_oe = ser_oe;
    // Step tick divider
    d.tick = 1'b0;
    if (q.step >= step_len - 11'h1) begin
      d.step = 11'h0;
      d.tick = 1'b1;
    end else begin
      d.step = q.step + 11'h1;
    end
    // Start delay countdown blocks writes
    if (q.delay != 32'h0) begin
      d.delay = q.delay - 32'h1;
    end
    // Status read clears; new events win over the clear
    if (rd_pulse && wr_sel == brc_pkg::REG_FLAGS) begin
      d.flg = brc_pkg::RST_FLAGS;
    end
    if (thr_m[1]) d.flg[brc_pkg::FLG_THERMAL] = 1'b1;
    if (ret_m[1]) d.flg[brc_pkg::FLG_RETRY] = 1'b1;
    if (uv_m[1]) d.flg[brc_pkg::FLG_UNDERVOLT] = 1'b1;
    // Register writes, primary and alternate codes and control
    if (wr_pulse && q.delay == 32'h0) begin
      if (wr_sel == brc_pkg::REG_PRIMARY) begin
        d.prim = wr_data;
      end else if (wr_sel == brc_pkg::REG_ALTERNATE) begin
        d.alt = wr_data;
      end else if (wr_sel == brc_pkg::REG_CONTROL) begin
        d.ctl = wr_data;
        // Re-enable restarts without the start delay
        if (wr_data[brc_pkg::CTL_ENABLE] && !q.ctl[brc_pkg::CTL_ENABLE]) d.restart = 1'b1;
        if (wr_data[brc_pkg::CTL_SOFT_RESET]) begin
          // Soft reset: defaults and a fresh start
          d.prim = brc_pkg::RST_VOLTAGE;
          d.alt = brc_pkg::RST_VOLTAGE;
          d.ctl = brc_pkg::RST_CONTROL;
          d.flg = brc_pkg::RST_FLAGS;
          d.delay = 32'(START_DELAY);
        end
      end
    end
    // Chip activate falling edge resets the bank
    if (q.act_d && !act_m[1]) begin
      d.prim = brc_pkg::RST_VOLTAGE;
      d.alt = brc_pkg::RST_VOLTAGE;
      d.ctl = brc_pkg::RST_CONTROL;
      d.flg = brc_pkg::RST_FLAGS;
    end
    // Forced pulse width: always, or during voltage change
    d.forced_pulse_width_mode = d.ctl[brc_pkg::CTL_FORCED_PULSE_WIDTH_MODE] | (d.ctl[brc_pkg::CTL_FORCED_PULSE_WIDTH_MODE_ON_CHANGE] & VOLTAGE_CHANGING);
    // Pending flag registered so the pin comes from a flip-flop
    d.pend = d.delay != 32'h0;
  end

  // Single register stage for all bank state
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      q <= '0;
      q.prim <= brc_pkg::RST_VOLTAGE;
      q.alt <= brc_pkg::RST_VOLTAGE;
      q.ctl <= brc_pkg::RST_CONTROL;
      q.flg <= brc_pkg::RST_FLAGS;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from flip-flops, except SDA_OUT which is tied low
  assign SDA_OUT = 1'b0;
  assign SDA_OE = q.sda_oe;
  assign PRIMARY_VOLTAGE_CODE = q.prim;
  assign ALTERNATE_VOLTAGE_CODE = q.alt;
  assign CONVERTER_ENABLE = q.ctl[brc_pkg::CTL_ENABLE];
  assign RESTART_NO_DELAY = q.restart;
  assign FORCED_PULSE_WIDTH_MODE = q.forced_pulse_width_mode;
  assign OUTPUT_DISCHARGE = q.ctl[brc_pkg::CTL_DISCHARGE];
  assign RETRY_SHORT_PROTECTION = q.ctl[brc_pkg::CTL_RETRY];
  assign STEP_TICK = q.tick;
  assign START_PENDING = q.pend;
endmodule

// >>> test/brc_monitor.sv
// Port-level checker of the regulator register bank
`timescale 1ns/1ps
module brc_monitor #(
  parameter int START_DELAY = 50
) (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic SCL_IN,
  input wire logic SDA_OE,
  input wire logic CHIP_ACTIVATE,
  input wire logic [7:0] PRIMARY_VOLTAGE_CODE,
  input wire logic [7:0] ALTERNATE_VOLTAGE_CODE,
  input wire logic CONVERTER_ENABLE,
  input wire logic RESTART_NO_DELAY,
  input wire logic OUTPUT_DISCHARGE,
  input wire logic RETRY_SHORT_PROTECTION,
  input wire logic STEP_TICK,
  input wire logic START_PENDING
);
  // One clock domain, so one default clock and reset
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  // Cycles spent so far in the start delay
  int pend_cnt;
  // Counter clears outside the delay so a second soft reset starts fresh
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST || !START_PENDING) begin
      pend_cnt <= 0;
    end else begin
      pend_cnt <= pend_cnt + 1;
    end
  end
  // Ack and read data may only move while the bus clock is low
  property p_sda_low_scl;
    $changed(SDA_OE) |-> !SCL_IN;
  endproperty
  a_sda_low_scl: assert property (p_sda_low_scl) else $error("data pin moved with clock high");
  property p_restart_en;
    RESTART_NO_DELAY |-> ##[0:1] CONVERTER_ENABLE;
  endproperty
  a_restart_en: assert property (p_restart_en) else $error("restart without enable");
  property p_restart_pulse;
    RESTART_NO_DELAY |=> !RESTART_NO_DELAY;
  endproperty
  a_restart_pulse: assert property (p_restart_pulse) else $error("restart pulse too long");
  property p_activate;
    $fell(CHIP_ACTIVATE) |-> ##[1:8] (PRIMARY_VOLTAGE_CODE == 8'h64 && ALTERNATE_VOLTAGE_CODE == 8'h64
      && CONVERTER_ENABLE && OUTPUT_DISCHARGE && RETRY_SHORT_PROTECTION);
  endproperty
  a_activate: assert property (p_activate) else $error("activate fall kept values");
  property p_soft_defaults;
    $rose(START_PENDING) |-> ##[0:2] (PRIMARY_VOLTAGE_CODE == 8'h64 && ALTERNATE_VOLTAGE_CODE == 8'h64);
  endproperty
  a_soft_defaults: assert property (p_soft_defaults) else $error("soft reset kept codes");
  property p_pending_hold;
    START_PENDING [*3] |-> $stable(PRIMARY_VOLTAGE_CODE);
  endproperty
  a_pending_hold: assert property (p_pending_hold) else $error("write landed in start delay");
  property p_pending_len;
    $fell(START_PENDING) |-> pend_cnt >= START_DELAY - 1 && pend_cnt <= START_DELAY + 1;
  endproperty
  a_pending_len: assert property (p_pending_len) else $error("start delay length wrong");
  property p_step_pulse;
    STEP_TICK |=> !STEP_TICK [*8];
  endproperty
  a_step_pulse: assert property (p_step_pulse) else $error("step ticks too close");
endmodule
bind brc_top brc_monitor #(.START_DELAY(START_DELAY)) mon_u (.CLK_SYS, .SYS_RST, .SCL_IN, .SDA_OE, .CHIP_ACTIVATE,
  .PRIMARY_VOLTAGE_CODE, .ALTERNATE_VOLTAGE_CODE, .CONVERTER_ENABLE, .RESTART_NO_DELAY, .OUTPUT_DISCHARGE,
  .RETRY_SHORT_PROTECTION, .STEP_TICK, .START_PENDING);

// >>> test/brc_host.sv
// Two-wire bus host model driving the bank's serial pins
`timescale 1ns/1ps
module brc_host (
  output logic scl,
  output logic sda_pull,
  input wire logic sda_in
);
  // Quarter of the 48 ns link clock
  localparam time Q = 12ns;
  // Idle: clock stands high, data left to the pull-up
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // Start; long first wait lets the target drop a pending ack
  task automatic start();
    sda_pull = 1'b0;
    #(Q * 3);
    scl = 1'b1;
    #Q;
    sda_pull = 1'b1;
    #Q;
    scl = 1'b0;
    #Q;
  endtask
  // Stop, then the clock stands still
  task automatic stop();
    sda_pull = 1'b1;
    #Q;
    scl = 1'b1;
    #Q;
    sda_pull = 1'b0;
    #(Q * 2);
  endtask
  // Nine bit times, msb first; a 1 releases the line so the target can talk
  task automatic byte9(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_pull = !tx[i];
      #Q;
      scl = 1'b1;
      #Q;
      rx[i] = sda_in;
      #Q;
      scl = 1'b0;
      #Q;
    end
  endtask
  // Register write; nak bits are address, select, data
  task automatic wr(input logic [6:0] adr, input logic [7:0] sel, input logic [7:0] dat, output logic [2:0] nak);
    logic [8:0] r;
    start();
    byte9({adr, 1'b0, 1'b1}, r);
    nak[2] = r[0];
    byte9({sel, 1'b1}, r);
    nak[1] = r[0];
    byte9({dat, 1'b1}, r);
    nak[0] = r[0];
    stop();
  endtask
  // Register read through a repeated start, ended by a host nack
  task automatic rd(input logic [6:0] adr, input logic [7:0] sel, output logic [7:0] dat);
    logic [8:0] r;
    start();
    byte9({adr, 1'b0, 1'b1}, r);
    byte9({sel, 1'b1}, r);
    start();
    byte9({adr, 1'b1, 1'b1}, r);
    byte9(9'h1FF, r);
    dat = r[8:1];
    stop();
  endtask
endmodule

// >>> test/testbench.sv
// Self-checking bench of the regulator register bank
`timescale 1ns/1ps
module testbench;
  // Own address, top bit set so it can match
  localparam logic [6:0] ADR = 7'h55;
  localparam int LIMIT = 100000;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic chip_act = 1'b1;
  logic volt_chg = 1'b0;
  // Events: thermal, retry, undervoltage
  logic [2:0] ev = 3'h0;
  logic [6:0] tgt = ADR;
  logic scl, sda_pull, sda_out, sda_oe, en, rnd, forced_pulse_width_mode, dis, rty, tick, pend;
  logic [7:0] prim, alt, v;
  logic [2:0] nk;
  logic [7:0] flg [3] = '{8'h10, 8'h08, 8'h01};
  int steps [4] = '{brc_pkg::STEP0_CYC, brc_pkg::STEP1_CYC, brc_pkg::STEP2_CYC, brc_pkg::STEP3_CYC};
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  int n_restart = 0;
  int g;
  // Open-drain data wire with pull-up
  wire sda_w = !(sda_pull || sda_oe);
  // Short start delay keeps the run brief
  brc_top #(.START_DELAY(2000)) dut_u (
    .CLK_SYS(clk_sys), .SYS_RST(sys_rst), .SCL_IN(scl), .SDA_IN(sda_w), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .TARGET_ADDR(tgt), .CHIP_ACTIVATE(chip_act), .THERMAL_WARN(ev[2]), .RETRY_ENTERED(ev[1]),
    .INPUT_UNDERVOLT(ev[0]), .VOLTAGE_CHANGING(volt_chg), .PRIMARY_VOLTAGE_CODE(prim),
    .ALTERNATE_VOLTAGE_CODE(alt), .CONVERTER_ENABLE(en), .RESTART_NO_DELAY(rnd), .FORCED_PULSE_WIDTH_MODE(forced_pulse_width_mode),
    .OUTPUT_DISCHARGE(dis), .RETRY_SHORT_PROTECTION(rty), .STEP_TICK(tick), .START_PENDING(pend)
  );
  brc_host host_u (.scl(scl), .sda_pull(sda_pull), .sda_in(sda_w));
  // 250 MHz system clock
  initial begin
    forever #2 clk_sys = !clk_sys;
  end
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic r_chk(input string nm, input logic [7:0] sel, input logic [7:0] exp);
    host_u.rd(ADR, sel, v);
    check(nm, {8'h00, v}, {8'h00, exp});
  endtask
  task automatic w(input logic [7:0] sel, input logic [7:0] dat);
    host_u.wr(ADR, sel, dat, nk);
    check("write acks", {13'h0000, nk}, 16'h0000);
  endtask
  // Outputs sampled on falling edges, where they are settled
  task automatic clocks(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // Counts cycles to the next step tick, bounded
  task automatic tick_wait();
    g = 0;
    do begin
      clocks(1);
      g++;
    end while (tick !== 1'b1 && g < 3000);
  endtask
  task automatic close_out();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Restart pulse count and hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (rnd === 1'b1) begin
      n_restart <= n_restart + 1;
    end
    if (cyc == LIMIT) begin
      n_mismatch = n_mismatch + 1;
      close_out();
    end
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    clocks(6);
    r_chk("primary", 8'h01, 8'h64);
    r_chk("alternate", 8'h02, 8'h64);
    r_chk("control", 8'h03, 8'h6F);
    r_chk("flags", 8'h05, 8'h00);
    check("control pins", {12'h000, en, forced_pulse_width_mode, dis, rty}, 16'h000B);
    check("data out level", {15'h0000, sda_out}, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      if (i == 0 || i == 4 || i > 5) r_chk("unmapped", 8'(i), 8'h00);
    end
    // Strap with top bit clear can never match; a neighbour address is ignored
    @(posedge clk_sys);
    tgt <= 7'h15;
    clocks(1);
    host_u.wr(7'h15, 8'h01, 8'h00, nk);
    check("low address acks", {13'h0000, nk}, 16'h0007);
    @(posedge clk_sys);
    tgt <= ADR;
    clocks(1);
    host_u.wr(7'h56, 8'h01, 8'h00, nk);
    check("foreign acks", {13'h0000, nk}, 16'h0007);
    w(8'h01, 8'hFF);
    check("primary pin", {8'h00, prim}, 16'h00FF);
    w(8'h02, 8'h00);
    check("alternate pin", {8'h00, alt}, 16'h0000);
    w(8'h09, 8'h11);
    r_chk("select upper", 8'h01, 8'hFF);
    w(8'h03, 8'h10);
    check("control pins", {12'h000, en, forced_pulse_width_mode, dis, rty}, 16'h0004);
    r_chk("control", 8'h03, 8'h10);
    r_chk("kept", 8'h01, 8'hFF);
    w(8'h03, 8'h60);
    check("restarts", 16'(n_restart), 16'h0001);
    // Forced mode during change with bit6 set, then clear
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys);
      volt_chg <= 1'b1;
      clocks(4);
      check("forced on change", {15'h0000, forced_pulse_width_mode}, 16'(1 - i));
      @(posedge clk_sys);
      volt_chg <= 1'b0;
      clocks(4);
      check("forced after change", {15'h0000, forced_pulse_width_mode}, 16'h0000);
      w(8'h03, 8'h20);
    end
    for (int k = 0; k < 4; k++) begin
      w(8'h03, 8'h20 | 8'(k));
      tick_wait();
      tick_wait();
      check("step time", 16'(g), 16'(steps[k]));
    end
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      ev <= 3'b100 >> i;
      clocks(6);
      @(posedge clk_sys);
      ev <= 3'h0;
      clocks(6);
      r_chk("flag set", 8'h05, flg[i]);
      r_chk("flag cleared", 8'h05, 8'h00);
    end
    // Soft reset with a flag pending and a write during the delay
    @(posedge clk_sys);
    ev <= 3'h1;
    clocks(3);
    @(posedge clk_sys);
    ev <= 3'h0;
    clocks(1);
    w(8'h03, 8'h80);
    check("start pending", {15'h0000, pend}, 16'h0001);
    host_u.wr(ADR, 8'h01, 8'h21, nk);
    check("pending write acks", {13'h0000, nk}, 16'h0000);
    for (g = 0; g < 3000 && pend === 1'b1; g++) clocks(1);
    check("pending ended", {15'h0000, pend}, 16'h0000);
    r_chk("primary", 8'h01, 8'h64);
    r_chk("control", 8'h03, 8'h6F);
    r_chk("flags", 8'h05, 8'h00);
    w(8'h01, 8'h21);
    r_chk("primary", 8'h01, 8'h21);
    @(posedge clk_sys);
    chip_act <= 1'b0;
    clocks(8);
    check("activate reset", {8'h00, prim}, 16'h0064);
    @(posedge clk_sys);
    chip_act <= 1'b1;
    clocks(4);
    close_out();
  end
endmodule
